/* File: design/adspc_control_port.v */
// serial control port of the audio processor with its memories and registers
`timescale 1ns/1ps
`include "adspc_defines.vh"
module adspc_control_port (
    // clock, reset, enable
    input wire clk,
    input wire rst,
    input wire ce,
    // pins
    input wire transaction_latch_n,
    input wire control_bit_clock,
    input wire control_serial_in,
    input wire address_select,
    output reg control_serial_out,
    output reg control_serial_out_oe,
    // core side
    input wire core_frame_start,
    input wire core_param_busy,
    input wire [9:0] core_param_addr,
    output reg [27:0] core_param_rdata,
    output reg core_param_blocked,
    output wire init_done,
    output wire core_halt_n
);
//////////////////////////////////////////////////////////////////////
reg [2:0] latch_s_q, sclk_s_q, sin_s_q;
reg [1:0] asel_s_q;
wire latch_n = latch_s_q[2];
wire rise = sclk_s_q[2:1] == 2'b01;
wire fall = sclk_s_q[2:1] == 2'b10;
wire frame_end = latch_s_q[2:1] == 2'b01;
always @(posedge clk) begin
    if (rst) begin
        latch_s_q <= 3'h7;
        sclk_s_q <= 3'h0;
        sin_s_q <= 3'h0;
        asel_s_q <= 2'h0;
    end else if (ce) begin
        // first stage feeds only the second
        latch_s_q <= {latch_s_q[1:0], transaction_latch_n};
        sclk_s_q <= {sclk_s_q[1:0], control_bit_clock};
        sin_s_q <= {sin_s_q[1:0], control_serial_in};
        asel_s_q <= {asel_s_q[0], address_select};
    end
end
//////////////////////////////////////////////////////////////////////
reg [39:0] param_mem [0:1023];
reg [39:0] prog_mem [0:1535];
reg [39:0] tgt_mem [0:63];
reg [39:0] sl_data_q [0:4];
reg [15:0] sl_addr_q [0:4];
reg [15:0] cap_cfg_q [0:5];
reg [15:0] ocap_q [0:1];
reg [15:0] core_ctrl_q, ofmt_lo_q, ofmt_hi_q;
reg [7:0] mem_cfg_q, ifmt_q;
reg [13:0] init_cnt_q;
reg [10:0] init_addr_q;
reg [2:0] sl_cnt_q;
reg sl_pend_q;
assign init_done = init_cnt_q == `ADSPC_INIT_CYCLES;
assign core_halt_n = core_ctrl_q[`ADSPC_CORE_HALT_BIT];
//////////////////////////////////////////////////////////////////////
reg [2:0] bitc_q;
reg [7:0] shin_q;
reg [1:0] bytec_q;
reg [2:0] wbyte_q;
reg rd_q, sel_q, dead_q;
reg [11:0] addr_q;
reg [39:0] word_q;
reg [39:0] rdsh_q;
wire [7:0] byte_in = {shin_q[6:0], sin_s_q[2]};
//////////////////////////////////////////////////////////////////////
// address regions of the port
localparam RG_PARAM = 4'h0;
localparam RG_PROG = 4'h1;
localparam RG_TGT = 4'h2;
localparam RG_SLD = 4'h3;
localparam RG_SLA = 4'h4;
localparam RG_CAP = 4'h5;
localparam RG_OCAP = 4'h6;
localparam RG_CORE = 4'h7;
localparam RG_MCFG = 4'h8;
localparam RG_OLO = 4'h9;
localparam RG_OHI = 4'ha;
localparam RG_IFMT = 4'hb;
localparam RG_NONE = 4'hf;
// offsets wrap outside their region, but are only used inside it
wire [11:0] prog_off = addr_q - `ADSPC_PROG_FIRST;
wire [11:0] sld_off = addr_q - `ADSPC_SLD_FIRST;
wire [11:0] sla_off = addr_q - `ADSPC_SLA_FIRST;
wire [11:0] cap_off = addr_q - `ADSPC_CAP_FIRST;
// safeload slot under transfer
wire [2:0] sl_slot = sl_cnt_q - 3'h1;
wire [11:0] sl_tgt = sl_addr_q[sl_slot][11:0];
wire [39:0] sl_word = sl_data_q[sl_slot];
reg [3:0] region;
always @* begin
    region = RG_NONE;
    if (addr_q <= `ADSPC_PARAM_LAST) begin
        region = RG_PARAM;
    end else if (addr_q <= `ADSPC_PROG_LAST) begin
        region = RG_PROG;
    end else if (addr_q <= `ADSPC_TGT_LAST) begin
        region = RG_TGT;
    end else if (addr_q <= `ADSPC_SLD_LAST) begin
        region = RG_SLD;
    end else if (addr_q <= `ADSPC_SLA_LAST) begin
        region = RG_SLA;
    end else if (addr_q <= `ADSPC_CAP_LAST) begin
        region = RG_CAP;
    end else if (addr_q <= `ADSPC_OCAP_LAST) begin
        region = RG_OCAP;
    end else if (addr_q == `ADSPC_CORE_CTRL) begin
        region = RG_CORE;
    end else if (addr_q == `ADSPC_MEM_CFG) begin
        region = RG_MCFG;
    end else if (addr_q == `ADSPC_OFMT_LO) begin
        region = RG_OLO;
    end else if (addr_q == `ADSPC_OFMT_HI) begin
        region = RG_OHI;
    end else if (addr_q == `ADSPC_IFMT) begin
        region = RG_IFMT;
    end
end
// word length in bytes for each direction
reg [2:0] rd_len, wr_len;
always @* begin
    case (region)
        RG_PARAM: begin
            rd_len = 3'h4;
            wr_len = 3'h4;
        end
        RG_PROG, RG_TGT, RG_SLD: begin
            rd_len = 3'h5;
            wr_len = 3'h5;
        end
        RG_CAP: begin
            rd_len = 3'h3;
            wr_len = 3'h2;
        end
        RG_MCFG, RG_IFMT: begin
            rd_len = 3'h1;
            wr_len = 3'h1;
        end
        default: begin
            // safeload address, output capture, two-byte registers, unmapped
            rd_len = 3'h2;
            wr_len = 3'h2;
        end
    endcase
end
reg [39:0] rd_val;
always @* begin
    rd_val = 40'h0;
    case (region)
        RG_PARAM: begin
            rd_val = {12'h0, param_mem[addr_q[9:0]][27:0]};
        end
        RG_PROG: begin
            rd_val = prog_mem[prog_off[10:0]];
        end
        RG_CAP: begin
            rd_val = {24'h0, cap_cfg_q[cap_off[2:0]]};
        end
        RG_CORE: begin
            rd_val = {24'h0, core_ctrl_q};
        end
        RG_MCFG: begin
            rd_val = {32'h0, mem_cfg_q};
        end
        RG_OLO: begin
            rd_val = {24'h0, ofmt_lo_q};
        end
        RG_OHI: begin
            rd_val = {24'h0, ofmt_hi_q};
        end
        RG_IFMT: begin
            rd_val = {32'h0, ifmt_q};
        end
        default: begin
            // write-only regions read back as zero
            rd_val = 40'h0;
        end
    endcase
end
// left-justify the read word so the msb goes first
reg [39:0] rd_aligned;
always @* begin
    case (rd_len)
        3'h1: rd_aligned = {rd_val[7:0], 32'h0};
        3'h2: rd_aligned = {rd_val[15:0], 24'h0};
        3'h3: rd_aligned = {rd_val[23:0], 16'h0};
        3'h4: rd_aligned = {rd_val[31:0], 8'h0};
        default: rd_aligned = rd_val;
    endcase
end
wire [39:0] word_full = {word_q[31:0], byte_in};
wire last_byte = wbyte_q + 3'h1 == (rd_q ? rd_len : wr_len);
//////////////////////////////////////////////////////////////////////
integer i;
always @(posedge clk) begin
    if (rst) begin
        bitc_q <= 3'h0;
        shin_q <= 8'h0;
        bytec_q <= 2'h0;
        wbyte_q <= 3'h0;
        rd_q <= 1'b0;
        sel_q <= 1'b0;
        dead_q <= 1'b0;
        addr_q <= 12'h0;
        word_q <= 40'h0;
        rdsh_q <= 40'h0;
        control_serial_out <= 1'b0;
        control_serial_out_oe <= 1'b0;
        core_param_blocked <= 1'b0;
        core_param_rdata <= 28'h0;
        core_ctrl_q <= 16'h0;
        mem_cfg_q <= 8'h0;
        ofmt_lo_q <= 16'h0;
        ofmt_hi_q <= 16'h0;
        ifmt_q <= 8'h0;
        init_cnt_q <= 14'h0;
        init_addr_q <= 11'h0;
        sl_cnt_q <= 3'h0;
        sl_pend_q <= 1'b0;
        for (i = 0; i < 6; i = i + 1) begin
            cap_cfg_q[i] <= 16'h0;
        end
        for (i = 0; i < 5; i = i + 1) begin
            sl_data_q[i] <= 40'h0;
            sl_addr_q[i] <= 16'h0;
        end
        for (i = 0; i < 2; i = i + 1) begin
            ocap_q[i] <= 16'h0;
        end
    end else if (ce) begin
        core_param_rdata <= param_mem[core_param_addr][27:0];
        // boot load: contents cleared as stand-in for boot image
        if (!init_done) begin
            init_cnt_q <= init_cnt_q + 14'h1;
            if (init_addr_q != 11'h600) begin
                prog_mem[init_addr_q] <= 40'h0;
                if (init_addr_q < 11'h400) begin
                    param_mem[init_addr_q[9:0]] <= 40'h0;
                end
                init_addr_q <= init_addr_q + 11'h1;
            end
        end
        // safeload: one pair per idle cycle, armed by a write to slot 4
        if (core_frame_start && sl_cnt_q == 3'h0 && sl_pend_q)
            sl_cnt_q <= 3'h1;
        if (sl_cnt_q != 3'h0 && !core_param_busy) begin
            // program and register targets are dropped on purpose
            if (sl_tgt <= `ADSPC_PARAM_LAST) begin
                param_mem[sl_tgt[9:0]] <= sl_word;
            end else if (sl_tgt >= `ADSPC_TGT_FIRST && sl_tgt <= `ADSPC_TGT_LAST) begin
                tgt_mem[sl_tgt[5:0]] <= sl_word;
            end
            if (sl_cnt_q == 3'h5) begin
                sl_cnt_q <= 3'h0;
                sl_pend_q <= 1'b0;
            end else begin
                sl_cnt_q <= sl_cnt_q + 3'h1;
            end
        end
        if (latch_n) begin
            bitc_q <= 3'h0;
            bytec_q <= 2'h0;
            wbyte_q <= 3'h0;
            sel_q <= 1'b0;
            dead_q <= 1'b0;
            control_serial_out_oe <= 1'b0;
            core_param_blocked <= 1'b0;
        end else begin
            if (rise) begin
                shin_q <= byte_in;
                bitc_q <= bitc_q + 3'h1;
                if (bitc_q == 3'h7 && !dead_q) begin
                    if (bytec_q == 2'h0) begin
                        rd_q <= byte_in[0];
                        sel_q <= byte_in[7:1] == {`ADSPC_CHIP_ADDR_HI, asel_s_q[1]};
                        dead_q <= byte_in[7:1] != {`ADSPC_CHIP_ADDR_HI, asel_s_q[1]};
                        bytec_q <= 2'h1;
                    end else if (bytec_q == 2'h1) begin
                        addr_q[11:8] <= byte_in[3:0];
                        bytec_q <= 2'h2;
                    end else if (bytec_q == 2'h2) begin
                        addr_q[7:0] <= byte_in;
                        bytec_q <= 2'h3;
                    end else begin
                        word_q <= word_full;
                        if (last_byte) begin
                            wbyte_q <= 3'h0;
                        end else begin
                            wbyte_q <= wbyte_q + 3'h1;
                        end
                        if (last_byte) begin
                            addr_q <= addr_q + 12'h1;
                            if (!rd_q && sel_q) begin
                                case (region)
                                    RG_PARAM: begin
                                        param_mem[addr_q[9:0]] <= {12'h0, word_full[27:0]};
                                        core_param_blocked <= 1'b1;
                                    end
                                    RG_PROG: begin
                                        prog_mem[prog_off[10:0]] <= word_full;
                                    end
                                    RG_SLD: begin
                                        sl_data_q[sld_off[2:0]] <= word_full;
                                        // last data slot arms the transfer
                                        if (addr_q == `ADSPC_SLD_LAST) begin
                                            sl_pend_q <= 1'b1;
                                        end
                                    end
                                    RG_SLA: begin
                                        sl_addr_q[sla_off[2:0]] <= word_full[15:0];
                                    end
                                    RG_CAP: begin
                                        cap_cfg_q[cap_off[2:0]] <= word_full[15:0];
                                    end
                                    RG_OCAP: begin
                                        ocap_q[addr_q[0]] <= word_full[15:0];
                                    end
                                    RG_CORE: begin
                                        core_ctrl_q <= word_full[15:0];
                                    end
                                    RG_MCFG: begin
                                        mem_cfg_q <= word_full[7:0];
                                    end
                                    RG_OLO: begin
                                        ofmt_lo_q <= word_full[15:0];
                                    end
                                    RG_OHI: begin
                                        ofmt_hi_q <= word_full[15:0];
                                    end
                                    RG_IFMT: begin
                                        ifmt_q <= word_full[7:0];
                                    end
                                    default: begin
                                        // direct target writes and unmapped words are dropped
                                        ocap_q[0] <= ocap_q[0];
                                    end
                                endcase
                            end
                        end
                    end
                end
            end
            // read path: load a word at each word boundary on the falling edge
            if (fall && rd_q && sel_q && bytec_q == 2'h3) begin
                control_serial_out_oe <= 1'b1;
                if (bitc_q == 3'h0 && wbyte_q == 3'h0) begin
                    control_serial_out <= rd_aligned[39];
                    rdsh_q <= {rd_aligned[38:0], 1'b0};
                end else begin
                    control_serial_out <= rdsh_q[39];
                    rdsh_q <= {rdsh_q[38:0], 1'b0};
                end
            end
        end
        if (frame_end) begin
            control_serial_out_oe <= 1'b0;
        end
    end
end
endmodule

/* File: design/adspc_defines.vh */
// constants and field layout of the serial control port
// Operation
// - host frames each transaction by holding the latch line low throughout
// - serial input sampled on every rising edge of the bit clock
// - read data shifts out on falling edges, host captures on rising
// - serial output undriven except during an active read transaction
// - read output driving starts at the fourth byte, after address bytes
// - every field travels most-significant bit first
// - first byte: seven-bit chip address, then read flag in bit zero
// - chip address is zero or one by the address-select input
// - bytes two and three carry a twelve-bit location address
// - data from fourth byte, word width set by addressed region
// - burst: one start address, successive words go to next locations
// - 0x000-0x3ff parameter memory, 1024 by 28, four-byte words
// - 0x400-0x9ff instruction memory, 1536 by 40, five-byte words
// - ramp target memory not readable, written only through safeload
// - five safeload data registers five bytes, five address registers two
// - six capture registers take two-byte writes, read three bytes
// - core control and output formats two bytes, memory and input one
// - up to five safeload pairs copied to parameter or ramp target memory when core idle
// - safeload targets parameter memory and ramp target memory only
// - direct parameter writes make memory unavailable to the core
// - every location except ramp target memory reachable by single and burst transactions
// - at power-up both memories load from boot contents, here both are cleared to zero instead
// - initialization takes 8192 core cycles, host waits before writes
`ifndef ADSPC_DEFINES_VH
`define ADSPC_DEFINES_VH
`define ADSPC_PARAM_LAST 12'h3ff
`define ADSPC_PROG_FIRST 12'h400
`define ADSPC_PROG_LAST 12'h9ff
`define ADSPC_TGT_FIRST 12'ha00
`define ADSPC_TGT_LAST 12'ha3f
`define ADSPC_SLD_FIRST 12'ha40
`define ADSPC_SLD_LAST 12'ha44
`define ADSPC_SLA_FIRST 12'ha45
`define ADSPC_SLA_LAST 12'ha49
`define ADSPC_CAP_FIRST 12'ha4a
`define ADSPC_CAP_LAST 12'ha4f
`define ADSPC_OCAP_FIRST 12'ha50
`define ADSPC_OCAP_LAST 12'ha51
`define ADSPC_CORE_CTRL 12'ha52
`define ADSPC_MEM_CFG 12'ha53
`define ADSPC_OFMT_LO 12'ha54
`define ADSPC_OFMT_HI 12'ha55
`define ADSPC_IFMT 12'ha56
`define ADSPC_INIT_CYCLES 14'h2000
`define ADSPC_CHIP_ADDR_HI 6'h00
`define ADSPC_CORE_HALT_BIT 9
`endif

/* File: dv/adspc_control_port_asserts.sv */
// concurrent checks on the control port pins and core side
`timescale 1ns/1ps
module adspc_chk (
    // clock, reset and enable
    input wire clk,
    input wire rst,
    input wire ce,
    // pins
    input wire transaction_latch_n,
    input wire control_bit_clock,
    input wire control_serial_out,
    input wire control_serial_out_oe,
    // core side
    input wire core_param_blocked,
    input wire init_done,
    input wire core_halt_n
);
    reg [13:0] up_q;
    // saturates so a long run never wraps back under the boot window
    wire [13:0] up_d = (up_q == 14'h3fff) ? up_q : up_q + 14'h0001;
    always @(posedge clk) begin
        if (rst) begin
            up_q <= 14'h0000;
        end else if (ce) begin
            up_q <= up_d;
        end
    end
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    property p_oe_idle; transaction_latch_n [*6] |-> !control_serial_out_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("oe outside frame");
    property p_out_hold; (control_serial_out_oe && control_bit_clock) [*2] |-> $stable(control_serial_out); endproperty
    a_out_hold: assert property (p_out_hold) else $error("out moved in high phase");
    property p_oe_rise; $rose(control_serial_out_oe) |-> !transaction_latch_n && !$past(control_bit_clock, 2); endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("oe rose off a falling edge");
    property p_init_early; up_q < 14'h1ffc |-> !init_done; endproperty
    a_init_early: assert property (p_init_early) else $error("init done too early");
    property p_init_late; up_q > 14'h2004 |-> init_done; endproperty
    a_init_late: assert property (p_init_late) else $error("init done too late");
    property p_reset_vals; $fell(rst) |-> !control_serial_out_oe && !core_param_blocked && !init_done && !core_halt_n; endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("outputs not cleared by reset");
    property p_block_start; $rose(core_param_blocked) |-> !transaction_latch_n; endproperty
    a_block_start: assert property (p_block_start) else $error("blocked outside a write");
    property p_block_end; transaction_latch_n [*6] |-> !core_param_blocked; endproperty
    a_block_end: assert property (p_block_end) else $error("blocked after frame");
    property p_halt_frame; $changed(core_halt_n) |-> !transaction_latch_n; endproperty
    a_halt_frame: assert property (p_halt_frame) else $error("halt moved outside frame");
endmodule
bind adspc_control_port adspc_chk u_chk (.*);

/* File: dv/adspc_host_model.sv */
// host master model that drives the control port pins
`timescale 1ns/1ps
module adspc_host_model (
    // pins toward the device
    output reg transaction_latch_n = 1'b1,
    output reg control_bit_clock = 1'b0,
    output reg control_serial_in = 1'b0,
    input wire control_serial_out,
    input wire control_serial_out_oe
);
    reg last_q = 1'b0;
    reg saw_oe = 1'b0;
    // a released line shows the inverse of its last level, never a stale bit
    wire line_level = control_serial_out_oe ? control_serial_out : ~last_q;
    always @* if (control_serial_out_oe) last_q = control_serial_out;
    always @(posedge control_serial_out_oe) saw_oe = 1'b1;
    // bit clock stands low between frames, 200 ns period inside
    task xfer(input integer nbytes, input [255:0] tx, output [255:0] rx);
        integer i;
        begin
            rx = 256'h0;
            saw_oe = 1'b0;
            transaction_latch_n = 1'b0;
            #200;
            for (i = 0; i < nbytes * 8; i = i + 1) begin
                control_serial_in = tx[255 - i];
                #100 control_bit_clock = 1'b1;
                rx = {rx[254:0], line_level};
                #100 control_bit_clock = 1'b0;
            end
            #200 transaction_latch_n = 1'b1;
            control_serial_in = ~control_serial_in;
            #400;
        end
    endtask
endmodule

/* File: dv/tb_adspc_control_port.sv */
// self-checking bench for the serial control port
`timescale 1ns/1ps
module tb_adspc_control_port;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg ce = 1'b1;
    reg address_select = 1'b0;
    reg core_frame_start = 1'b0;
    reg core_param_busy = 1'b0;
    reg [9:0] core_param_addr = 10'h000;
    wire transaction_latch_n, control_bit_clock, control_serial_in, control_serial_out, control_serial_out_oe;
    wire [27:0] core_param_rdata;
    wire core_param_blocked, init_done, core_halt_n;
    integer bad_count = 0;
    integer checks = 0;
    integer cycles = 0;
    reg [6:0] chip = 7'h00;
    reg [255:0] rx;
    adspc_control_port DUT (.*);
    adspc_host_model host (.*);
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 50000) begin
            bad_count = bad_count + 1;
            end_of_test;
        end
    end
    ////////////////////////////////////////////////////////////////
    task check(input [255:0] seen, input [255:0] exp, input integer id);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("ERROR %0t check %0d seen %0h expected %0h", $time, id, seen, exp);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("mismatches %0d comparisons %0d", bad_count, checks);
            if (bad_count == 0 && checks > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    task wr(input [11:0] a, input integer n, input [199:0] d);
        host.xfer(3 + n, {chip, 1'b0, 4'h0, a, d << (8 * (25 - n)), 32'h0}, rx);
    endtask
    task rd(input [11:0] a, input integer n, input [199:0] e);
        begin
            host.xfer(3 + n, {chip, 1'b1, 4'h0, a, 232'h0}, rx);
            check(rx & ~({256{1'b1}} << (8 * n)), e, a);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task s_init;
        begin
            repeat (100) @(posedge clk);
            check(init_done, 0, 1);
            repeat (8150) @(posedge clk);
            #2 check(init_done, 1, 2);
            rd(12'h400, 5, 0);
        end
    endtask
    task s_param;
        begin
            wr(12'h005, 4, 32'hfabcdef1);
            rd(12'h005, 4, 32'h0abcdef1);
            @(posedge clk);
            #2 core_param_addr = 10'h005;
            repeat (2) @(posedge clk);
            #2 check(core_param_rdata, 28'habcdef1, 3);
            // enable low must freeze the core read port
            ce = 1'b0;
            core_param_addr = 10'h010;
            repeat (3) @(posedge clk);
            #2 check(core_param_rdata, 28'habcdef1, 8);
            ce = 1'b1;
        end
    endtask
    task s_burst;
        begin
            wr(12'ha52, 2, 16'h0000);
            check(core_halt_n, 0, 4);
            wr(12'h9fe, 10, 80'h1122334455_66778899aa);
            rd(12'h9fe, 10, 80'h1122334455_66778899aa);
            // trailing half word must be dropped, not stored
            wr(12'h3fe, 6, 48'h01020304_ffff);
            rd(12'h3fe, 8, 64'h01020304_00000000);
        end
    endtask
    task s_regs;
        integer i;
        integer n;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                n = (i == 1 || i == 4) ? 1 : 2;
                wr(12'ha52 + i, n, 16'h02c0 + i);
                rd(12'ha52 + i, n, (n == 1) ? 16'h00c0 + i : 16'h02c0 + i);
            end
            check(core_halt_n, 1, 5);
            wr(12'ha4b, 2, 16'h1234);
            rd(12'ha4b, 3, 24'h001234);
        end
    endtask
    task s_chip;
        begin
            @(posedge clk);
            #2 address_select = 1'b1;
            host.xfer(7, {8'h00, 4'h0, 12'h005, 32'h0, 200'h0}, rx);
            host.xfer(7, {8'h01, 4'h0, 12'h005, 232'h0}, rx);
            check(host.saw_oe, 0, 6);
            chip = 7'h01;
            rd(12'h005, 4, 32'h0abcdef1);
        end
    endtask
    task s_safe;
        begin
            wr(12'ha45, 10, 80'h0010_0400_0011_0a3f_0012);
            wr(12'ha40, 25, 200'hff01234567_00deadbeef_0007654321_00abcabcab_000fedcba9);
            rd(12'h010, 4, 0);
            @(posedge clk);
            #2 core_param_busy = 1'b1;
            core_frame_start = 1'b1;
            core_param_addr = 10'h010;
            @(posedge clk);
            #2 core_frame_start = 1'b0;
            repeat (20) @(posedge clk);
            #2 check(core_param_rdata, 0, 7);
            core_param_busy = 1'b0;
            repeat (20) @(posedge clk);
            #2 rd(12'h010, 12, 96'h01234567_07654321_0fedcba9);
            rd(12'h400, 5, 0);
            rd(12'ha00, 5, 0);
            rd(12'ha44, 5, 0);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #2 rst = 1'b0;
        s_init;
        s_param;
        s_burst;
        s_regs;
        s_chip;
        s_safe;
        end_of_test;
    end
endmodule
